// ---- rtl/gpm_mgmt_regs.v ----
// What this block does
// - Decode test select; nonzero picks pattern 1-7
// - Manual enable forces master/slave from value
// - Port type bit advertises multi or single
// - Advertise gigabit full/half duplex; reset ones
// - Auto cable test starts after link down
// - Config reserved bits ignore writes, read zero
// - Fault bit latches high, clears on read
// - Resolution bit shows master or slave
// - Local and remote receiver OK bits
// - Partner full/half duplex ability read-only
// - 8-bit idle error counter, clear on read
// - Extended set reached only via 0x0d/0x0e
// - Function 00 write loads extended pointer
// - Function 01 accesses pointed register, pointer kept
// - Function 10 increments after read and write
// - Function 11 increments after writes only
// - Ignore indirect access with other device address
// - Function 00 reads pointer, else pointed data
`timescale 1ns/10ps
`include "gpm_regs.vh"
module gpm_mgmt_regs #(
    parameter CNT_WIDTH = 8
) (
    input  wire        clk,
    input  wire        rst,
    // Management register access (already deserialised frame fields)
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    output reg         reg_rvalid,
    // Extended register set port
    output reg         ext_wr,
    output reg         ext_rd,
    output reg  [15:0] ext_addr,
    output reg  [15:0] ext_wdata,
    input  wire [15:0] ext_rdata,
    // PHY core status inputs
    input  wire        ms_fault_event,
    input  wire        ms_resolved_master,
    input  wire        local_rx_ok,
    input  wire        remote_rx_ok,
    input  wire        partner_fd,
    input  wire        partner_hd,
    input  wire        idle_error,
    input  wire        link_down,
    // PHY core control outputs
    output reg         test_active,
    output reg  [6:0]  test_pattern_sel,
    output reg         force_role,
    output reg         force_master,
    output reg         adv_multi_port,
    output reg         adv_gig_fd,
    output reg         adv_gig_hd,
    output reg         cable_test_start
);
    // ****************************************
    // Register storage
    // ****************************************
    reg  [15:0]          cfg;          // Writable part of configuration
    reg  [15:0]          acc_ctrl;     // Function code and device address
    reg  [15:0]          ext_ptr;      // Extended set pointer
    reg                  fault_flag;   // Sticky configuration fault
    wire [CNT_WIDTH-1:0] idle_count;   // Idle error count
    wire [1:0]           func;         // Indirect function code
    wire                 dev_ok;       // Device address matches vendor value
    wire                 hit_cfg;
    wire                 hit_sts;
    wire                 hit_acc;
    wire                 hit_dat;
    wire                 clear_sts;    // Status register read in progress
    wire [15:0]          sts_value;    // Status as seen before clearing
    reg  [15:0]          next_rdata;

    assign func    = acc_ctrl[`GPM_ACC_FUNC_HI:`GPM_ACC_FUNC_LO];
    assign dev_ok  = (acc_ctrl[4:0] == `GPM_TARGET_DEVICE_ADDRESS_VENDOR);
    assign hit_cfg = (reg_addr == `GPM_OFS_CONFIG);
    assign hit_sts = (reg_addr == `GPM_OFS_STATUS);
    assign hit_acc = (reg_addr == `GPM_OFS_ACC_CTRL);
    assign hit_dat = (reg_addr == `GPM_OFS_ADDR_DATA);
    assign clear_sts = reg_rd && hit_sts;

    // Status image; reserved 9:8 read zero
    assign sts_value = {fault_flag, ms_resolved_master, local_rx_ok, remote_rx_ok,
                        partner_fd, partner_hd, 2'b00, idle_count};

    // ****************************************
    // Idle error counter
    // ****************************************
    gpm_idle_counter #(
        .WIDTH (CNT_WIDTH)
    ) u_idle_cnt (
        .clk         (clk),
        .rst         (rst),
        .event_pulse (idle_error),
        .clear       (clear_sts),
        .count       (idle_count)
    );

    // ****************************************
    // Configuration and access control writes
    // ****************************************
    // Reserved bits masked so they never store
    always @(posedge clk)
    begin
        if (rst)
        begin
            cfg      <= `GPM_CFG_RESET;
            acc_ctrl <= `GPM_ACC_RESET;
        end
        else if (reg_wr)
        begin
            if (hit_cfg)
                cfg <= reg_wdata & `GPM_CFG_WMASK;
            if (hit_acc)
                acc_ctrl <= reg_wdata & `GPM_ACC_WMASK;
        end
    end

    // ****************************************
    // Fault flag: latch high, clear on read
    // ****************************************
    // A new fault in the read cycle wins over the clear
    always @(posedge clk)
    begin
        if (rst)
            fault_flag <= 1'b0;
        else if (ms_fault_event)
            fault_flag <= 1'b1;
        else if (clear_sts)
            fault_flag <= 1'b0;
    end

    // ****************************************
    // Extended pointer and indirect strobes
    // ****************************************
    // Strobes leave one cycle after the management access
    always @(posedge clk)
    begin
        if (rst)
        begin
            ext_ptr   <= `GPM_PTR_RESET;
            ext_wr    <= 1'b0;
            ext_rd    <= 1'b0;
            ext_addr  <= 16'h0000;
            ext_wdata <= 16'h0000;
        end
        else
        begin
            ext_wr <= 1'b0;
            ext_rd <= 1'b0;
            if (hit_dat && dev_ok && (reg_wr || reg_rd))
            begin
                case (func)
                    `GPM_FUNC_ADDR:
                    begin
                        if (reg_wr)
                            ext_ptr <= reg_wdata;
                    end
                    `GPM_FUNC_DATA:
                    begin
                        ext_wr    <= reg_wr;
                        ext_rd    <= reg_rd;
                        ext_addr  <= ext_ptr;
                        ext_wdata <= reg_wdata;
                    end
                    `GPM_FUNC_INC_RW:
                    begin
                        ext_wr    <= reg_wr;
                        ext_rd    <= reg_rd;
                        ext_addr  <= ext_ptr;
                        ext_wdata <= reg_wdata;
                        ext_ptr   <= ext_ptr + 16'h0001;
                    end
                    `GPM_FUNC_INC_W:
                    begin
                        ext_wr    <= reg_wr;
                        ext_rd    <= reg_rd;
                        ext_addr  <= ext_ptr;
                        ext_wdata <= reg_wdata;
                        if (reg_wr)
                            ext_ptr <= ext_ptr + 16'h0001;
                    end
                    default:
                    begin
                        ext_wr <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Read data selection
    // ****************************************
    // Data reads use the pointer combinationally; the extended side must
    // answer ext_rdata for the current pointer in the same cycle
    always @*
    begin
        next_rdata = 16'h0000;
        if (hit_cfg)
            next_rdata = cfg & `GPM_CFG_WMASK;
        else if (hit_sts)
            next_rdata = sts_value;
        else if (hit_acc)
            next_rdata = acc_ctrl;
        else if (hit_dat)
        begin
            if (!dev_ok)
                next_rdata = 16'h0000;
            else if (func == `GPM_FUNC_ADDR)
                next_rdata = ext_ptr;
            else
                next_rdata = ext_rdata;
        end
    end

    // Read answer registered one cycle after the request
    always @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    // ****************************************
    // Control outputs to the PHY core
    // ****************************************
    always @(posedge clk)
    begin
        if (rst)
        begin
            test_active      <= 1'b0;
            test_pattern_sel <= 7'h00;
            force_role       <= 1'b0;
            force_master     <= 1'b0;
            adv_multi_port   <= 1'b0;
            adv_gig_fd       <= 1'b1;
            adv_gig_hd       <= 1'b1;
            cable_test_start <= 1'b0;
        end
        else
        begin
            test_active <= (cfg[`GPM_CFG_TEST_HI:`GPM_CFG_TEST_LO] != 3'h0);
            test_pattern_sel <= 7'h00;
            if (cfg[`GPM_CFG_TEST_HI:`GPM_CFG_TEST_LO] != 3'h0)
                test_pattern_sel[cfg[`GPM_CFG_TEST_HI:`GPM_CFG_TEST_LO] - 3'h1] <= 1'b1;
            force_role   <= cfg[`GPM_CFG_MS_EN];
            force_master <= cfg[`GPM_CFG_MS_EN] & cfg[`GPM_CFG_MS_VAL];
            adv_multi_port <= cfg[`GPM_CFG_PORT_TYPE];
            adv_gig_fd     <= cfg[`GPM_CFG_ADV_FD];
            adv_gig_hd     <= cfg[`GPM_CFG_ADV_HD];
            cable_test_start <= link_down & cfg[`GPM_CFG_AUTO_CT];
        end
    end
endmodule // gpm_mgmt_regs

// ---- rtl/gpm_regs.vh ----
`ifndef GPM_REGS_VH
`define GPM_REGS_VH
// ****************************************
// Register offsets (management locations)
// ****************************************
`define GPM_OFS_CONFIG     5'h09
`define GPM_OFS_STATUS     5'h0a
`define GPM_OFS_ACC_CTRL   5'h0d
`define GPM_OFS_ADDR_DATA  5'h0e
// ****************************************
// Gigabit configuration fields
// ****************************************
`define GPM_CFG_TEST_HI    15
`define GPM_CFG_TEST_LO    13
`define GPM_CFG_MS_EN      12
`define GPM_CFG_MS_VAL     11
`define GPM_CFG_PORT_TYPE  10
`define GPM_CFG_ADV_FD     9
`define GPM_CFG_ADV_HD     8
`define GPM_CFG_AUTO_CT    7
`define GPM_CFG_RESET      16'h0300
`define GPM_CFG_WMASK      16'hff80
// ****************************************
// Gigabit status fields
// ****************************************
`define GPM_STS_FAULT      15
`define GPM_STS_RESOLVE    14
`define GPM_STS_LOC_RX     13
`define GPM_STS_REM_RX     12
`define GPM_STS_LP_FD      11
`define GPM_STS_LP_HD      10
// ****************************************
// Indirect access control fields
// ****************************************
`define GPM_ACC_FUNC_HI    15
`define GPM_ACC_FUNC_LO    14
`define GPM_ACC_WMASK      16'hc01f
`define GPM_ACC_RESET      16'h0000
`define GPM_TARGET_DEVICE_ADDRESS_VENDOR   5'h1f
`define GPM_FUNC_ADDR      2'h0
`define GPM_FUNC_DATA      2'h1
`define GPM_FUNC_INC_RW    2'h2
`define GPM_FUNC_INC_W     2'h3
`define GPM_PTR_RESET      16'h0000
`endif

// ---- rtl/gpm_idle_counter.v ----
`timescale 1ns/10ps
// ****************************************
// Saturating clear-on-read event counter
// ****************************************
module gpm_idle_counter #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             event_pulse,
    input  wire             clear,
    output reg  [WIDTH-1:0] count
);
    // Event in the clearing cycle restarts at one, so it is never lost
    always @(posedge clk)
    begin
        if (rst)
            count <= {WIDTH{1'b0}};
        else if (clear)
            count <= event_pulse ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
        else if (event_pulse && (count != {WIDTH{1'b1}}))
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
endmodule // gpm_idle_counter

// ---- verif/gpm_regs_props.sv ----
`timescale 1ns/10ps
// ****************************************
// Register slice checker
// ****************************************
module gpm_regs_props (
    input wire        clk,
    input wire        rst,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [4:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire        reg_rvalid,
    input wire        ext_wr,
    input wire        ext_rd,
    input wire        ms_resolved_master,
    input wire        local_rx_ok,
    input wire        link_down,
    input wire        test_active,
    input wire [6:0]  test_pattern_sel,
    input wire        force_role,
    input wire        adv_gig_fd,
    input wire        adv_gig_hd,
    input wire        cable_test_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Host steps: a config write, a status read
    sequence s_cfg_wr;
        reg_wr && reg_addr == 5'h09;
    endsequence
    sequence s_sts_rd;
        reg_rd && reg_addr == 5'h0a;
    endsequence
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
        else $error("stray read answer");
    AST_ADV_RST: assert property ($fell(rst) |-> adv_gig_fd && adv_gig_hd)
        else $error("advertise bits not set after reset");
    AST_TEST_SEL: assert property (test_active == (test_pattern_sel != 7'h00)
        && $onehot0(test_pattern_sel))
        else $error("test pattern select inconsistent");
    // Controls land two edges after the write that sets them
    AST_CFG_CTRL: assert property (s_cfg_wr ##2 1 |-> force_role == $past(reg_wdata[12], 2)
        && adv_gig_fd == $past(reg_wdata[9], 2)
        && test_active == ($past(reg_wdata[15:13], 2) != 3'h0))
        else $error("config controls wrong");
    AST_CABLE: assert property (cable_test_start |-> $past(link_down))
        else $error("cable test without link down");
    AST_EXT_WR: assert property (ext_wr |-> $past(reg_wr && reg_addr == 5'h0e))
        else $error("extended write without access");
    AST_EXT_RD: assert property (ext_rd |-> $past(reg_rd && reg_addr == 5'h0e))
        else $error("extended read without access");
    AST_STS: assert property (s_sts_rd |=> reg_rdata[9:8] == 2'b00
        && reg_rdata[14:13] == $past({ms_resolved_master, local_rx_ok}))
        else $error("status levels wrong");
    AST_CFG_RSVD: assert property (reg_rd && reg_addr == 5'h09 |=> reg_rdata[6:0] == 7'h00)
        else $error("reserved config bits nonzero");
endmodule // gpm_regs_props

bind gpm_mgmt_regs gpm_regs_props u_props (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ext_wr(ext_wr), .ext_rd(ext_rd),
    .ms_resolved_master(ms_resolved_master), .local_rx_ok(local_rx_ok),
    .link_down(link_down), .test_active(test_active), .test_pattern_sel(test_pattern_sel),
    .force_role(force_role), .adv_gig_fd(adv_gig_fd), .adv_gig_hd(adv_gig_hd),
    .cable_test_start(cable_test_start));

// ---- verif/gpm_ext_model.sv ----
`timescale 1ns/10ps
// ****************************************
// Extended register set model
// ****************************************
module gpm_ext_model (
    input  wire        clk,
    input  wire        ext_wr,
    input  wire [15:0] ext_addr,
    input  wire [15:0] ext_wdata,
    input  wire [15:0] ptr,
    output wire [15:0] ext_rdata
);
    reg [15:0] mem [0:255]; // Only the low byte of the pointer is decoded
    // Store on the write strobe
    always @(posedge clk)
        if (ext_wr)
            mem[ext_addr[7:0]] <= ext_wdata;
    // Data for the current pointer, combinational as the port expects
    assign ext_rdata = mem[ptr[7:0]];
endmodule // gpm_ext_model

// ---- verif/gige_phy_mgmt_config_status_regs_tb.sv ----
`timescale 1ns/10ps
// ****************************************
// Register slice testbench
// ****************************************
module gige_phy_mgmt_config_status_regs_tb;
    reg         clk = 1'b0;        // Device clock
    reg         rst = 1'b1;        // Sync reset
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [4:0]  reg_addr = 5'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg  [7:0]  st = 8'h00;        // Fault,res,loc,rem,pfd,phd,idle,link_down
    reg  [15:0] ptr = 16'h0000;    // Expected extended pointer
    wire [15:0] reg_rdata, ext_addr, ext_wdata, ext_rdata;
    wire [6:0]  sel;
    wire        reg_rvalid, ext_wr, ext_rd, t_act, f_role, f_mst, adv_mp, adv_fd, adv_hd, cts;
    integer     fails = 0, cmp_count = 0, cyc = 0, m;
    always #12.5 clk = ~clk;
    gpm_mgmt_regs u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ms_fault_event(st[7]),
        .ms_resolved_master(st[6]), .local_rx_ok(st[5]), .remote_rx_ok(st[4]),
        .partner_fd(st[3]), .partner_hd(st[2]), .idle_error(st[1]), .link_down(st[0]),
        .test_active(t_act), .test_pattern_sel(sel), .force_role(f_role),
        .force_master(f_mst), .adv_multi_port(adv_mp), .adv_gig_fd(adv_fd),
        .adv_gig_hd(adv_hd), .cable_test_start(cts));
    gpm_ext_model u_ext (.clk(clk), .ext_wr(ext_wr), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ptr(ptr), .ext_rdata(ext_rdata));
    // ****************************************
    // Shared tasks, all entered at a falling edge
    // ****************************************
    task chk(input [15:0] got, input [15:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [4:0] a, input [15:0] d);
    begin
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    end
    endtask
    // Answer is registered, so it is looked at one falling edge later
    task rd(input [4:0] a, input [15:0] exp);
    begin
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk(reg_rdata, exp);
    end
    endtask
    // Checks the extended write strobe launched by the last access;
    // one more edge lets the model store it before any read back
    task ew(input [15:0] a, input [15:0] d);
    begin
        chk({15'h0000, ext_wr}, 16'h0001);
        chk(ext_addr, a);
        chk(ext_wdata, d);
        @(negedge clk);
    end
    endtask
    task pulse_link_down;
    begin
        st[0] = 1'b1;
        @(negedge clk);
        st[0] = 1'b0;
    end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_config;
    begin
        rd(5'h09, 16'h0300);
        for (m = 0; m < 8; m = m + 1)
        begin
            wr(5'h09, {m[2:0], m[0], 1'b1, m[1], 2'b01, m[2], 7'h7f});
            @(negedge clk);
            chk({8'h00, t_act, sel}, {8'h00, m != 0, (m != 0) ? (7'h01 << (m - 1)) : 7'h00});
            chk({11'h000, f_role, f_role & f_mst, adv_mp, adv_fd, adv_hd},
                {11'h000, m[0], m[0], m[1], 2'b01});
            rd(5'h09, {m[2:0], m[0], 1'b1, m[1], 2'b01, m[2], 7'h00});
        end
        rd(5'h03, 16'h0000);
    end
    endtask
    task t_cable;
    begin
        wr(5'h09, 16'h1000);
        pulse_link_down;
        chk({15'h0000, cts}, 16'h0000);
        wr(5'h09, 16'h1080);
        pulse_link_down;
        chk({14'h0000, cts, f_mst}, 16'h0002);
    end
    endtask
    // Three idle errors and one fault, then reads that clear them
    task t_status;
    begin
        st = 8'hea;
        @(negedge clk);
        st = 8'h6a;
        repeat (2) @(negedge clk);
        st = 8'h68;
        rd(5'h0a, 16'he803);
        st = 8'h6a;
        rd(5'h0a, 16'h6800);
        st = 8'h68;
        rd(5'h0a, 16'h6801);
    end
    endtask
    task t_indirect;
    begin
        wr(5'h0d, 16'h001f);
        wr(5'h0e, 16'h0040);
        ptr = 16'h0040;
        rd(5'h0e, 16'h0040);
        wr(5'h0d, 16'h401f);
        wr(5'h0e, 16'h1234);
        ew(16'h0040, 16'h1234);
        rd(5'h0e, 16'h1234);
        wr(5'h0d, 16'h801f);
        wr(5'h0e, 16'haaaa);
        ew(16'h0040, 16'haaaa);
        ptr = 16'h0041;
        wr(5'h0e, 16'h5555);
        ew(16'h0041, 16'h5555);
        wr(5'h0d, 16'h001f);
        rd(5'h0e, 16'h0042);
        wr(5'h0e, 16'h0040);
        ptr = 16'h0040;
        wr(5'h0d, 16'hc01f);
        rd(5'h0e, 16'haaaa);
        rd(5'h0e, 16'haaaa);
        wr(5'h0e, 16'h0bad);
        ew(16'h0040, 16'h0bad);
        ptr = 16'h0041;
        wr(5'h0d, 16'h8001);
        wr(5'h0e, 16'hdead);
        chk({15'h0000, ext_wr}, 16'h0000);
        rd(5'h0e, 16'h0000);
        wr(5'h0d, 16'h801f);
        rd(5'h0e, 16'h5555);
    end
    endtask
    task results;
    begin
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    // Hang guard: the run needs about 65 cycles
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            fails = fails + 1;
            results;
        end
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_config;
        t_cable;
        t_status;
        t_indirect;
        results;
    end
endmodule // gige_phy_mgmt_config_status_regs_tb
